//--- rtl/ccm_pkg.sv
// Constants, modes and field layout for the CPU clock mode selector.
// Assumes one core_clk domain; straps and oscillator are pins into it.
// Function
// R1: Both CPU clock edges produce pipeline and bus activity strobes; strobes come only in direct drive and prescaler modes, none in PLL modes.
// R2: Clock phase time is the interval between two successive CPU clock edges.
// R3: Mode comes from the three-bit field in bits 7 to 5 of the latch.
// R4: Long hardware reset loads upper port byte levels into the latch.
// R5: Codes decode to x4, x3, x2, x5, 1:1, x1.5, /2, x2.5.
// R6: Code 001 bypasses the multiplier and uses a divide-by-two prescaler.
// R7: Prescaler mode runs the CPU clock at half oscillator frequency.
// R8: Prescaler high and low phases each last one oscillator period.
// R9: Captured configuration holds until the next long hardware reset.
package ccm_pkg;
	localparam int          CCM_LATCH_W      = 8;
	localparam int          CCM_CFG_LSB      = 5;
	localparam int          CCM_CFG_MSB      = 7;
	localparam logic [7:0]  CCM_LATCH_RESET  = 8'hff;
	localparam logic [3:0]  CCM_ADDR_LATCH   = 4'h0;
	localparam logic [3:0]  CCM_ADDR_MODE    = 4'h1;
	localparam logic [3:0]  CCM_ADDR_PHASE   = 4'h2;
	localparam logic [2:0]  CCM_CODE_X4      = 3'h7;
	localparam logic [2:0]  CCM_CODE_X3      = 3'h6;
	localparam logic [2:0]  CCM_CODE_X2      = 3'h5;
	localparam logic [2:0]  CCM_CODE_X5      = 3'h4;
	localparam logic [2:0]  CCM_CODE_DIRECT  = 3'h3;
	localparam logic [2:0]  CCM_CODE_X1P5    = 3'h2;
	localparam logic [2:0]  CCM_CODE_PRESC   = 3'h1;
	localparam logic [2:0]  CCM_CODE_X2P5    = 3'h0;

	typedef enum {
		CCM_MODE_PLL,
		CCM_MODE_DIRECT,
		CCM_MODE_PRESC
	} ccm_mode_t;

	// Factor in halves: x4 gives 8, /2 gives 1
	function automatic logic [3:0] ccm_factor_half(input logic [2:0] code);
		logic [3:0] f;
		f = 4'h0;
		case (code)
			CCM_CODE_X4:     f = 4'h8;
			CCM_CODE_X3:     f = 4'h6;
			CCM_CODE_X2:     f = 4'h4;
			CCM_CODE_X5:     f = 4'ha;
			CCM_CODE_DIRECT: f = 4'h2;
			CCM_CODE_X1P5:   f = 4'h3;
			CCM_CODE_PRESC:  f = 4'h1;
			default:         f = 4'h5;
		endcase
		return f;
	endfunction
endpackage

//--- rtl/ccm_sync.sv
// Three-stage pin synchroniser with agreement of the last two stages.
// Assumes input is asynchronous to core_clk.
`timescale 1ns/10ps
`default_nettype none
module ccm_sync #(
	parameter int W = 1
) (
	input  wire logic         core_clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] din,
	output var  logic [W-1:0] dout
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;

	// A zero-width bus leaves nothing to synchronise
	if (W < 1) begin : g_bad_width
		$error("ccm_sync needs W of at least 1");
	end

	// Only s2 reads s1; output changes once s2 and s3 agree
	always_ff @(posedge core_clk) begin
		if (rst) begin
			s1   <= '0;
			s2   <= '0;
			s3   <= '0;
			dout <= '0;
		end else begin
			s1 <= din;
			s2 <= s1;
			s3 <= s2;
			// Bits agree one by one, so a busy oscillator bit never stalls the straps
			dout <= (s3 & ~(s2 ^ s3)) | (dout & (s2 ^ s3));
		end
	end
endmodule
`default_nettype wire

//--- rtl/ccm_top.sv
// CPU clock mode selector: strap capture, mode decode, CPU clock generation.
// Assumes osc_in is far slower than core_clk, and hw_reset_long is a pin.
//
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module ccm_top
	import ccm_pkg::*;
(
	input  wire logic       core_clk,
	input  wire logic       rst,
	input  wire logic       hw_reset_long,
	input  wire logic [7:0] port0_upper_byte,
	input  wire logic       osc_in,
	input  wire logic [3:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	output logic      [2:0] clock_config_field,
	output logic      [3:0] factor_half,
	output logic            prescaler_active,
	output logic            pll_enable,
	output logic            cpu_clk_presc,
	output logic            cpu_edge_pulse,
	output logic            cpu_rise_pulse,
	output logic            cpu_fall_pulse
);
	logic [7:0] port_s;
	logic       rst_pin_s;
	logic       osc_s;
	logic       osc_d;
	logic [7:0] reset_config_latch_high;
	logic [2:0] latch_field;
	ccm_mode_t  mode;
	logic       osc_rise;
	logic       osc_edge;
	logic [7:0] clock_phase_time;
	logic [7:0] phase_cnt;

	ccm_sync #(.W(10)) u_sync (
		.core_clk (core_clk),
		.rst      (rst),
		.din      ({hw_reset_long, osc_in, port0_upper_byte}),
		.dout     ({rst_pin_s, osc_s, port_s})
	);

	// Edge history of the synchronised oscillator
	always_ff @(posedge core_clk) begin
		if (rst) begin
			osc_d <= 1'b0;
		end else begin
			osc_d <= osc_s;
		end
	end

	assign osc_rise = osc_s & ~osc_d;
	assign osc_edge = osc_s ^ osc_d;
	assign latch_field = reset_config_latch_high[CCM_CFG_MSB:CCM_CFG_LSB];

	// R4: strap capture under reset
	// Loaded every cycle while the pin reset is held, so the last level wins
	// R9: held after release
	always_ff @(posedge core_clk) begin
		if (rst) begin
			reset_config_latch_high <= CCM_LATCH_RESET;
		end else if (rst_pin_s) begin
			reset_config_latch_high <= port_s;
		end
	end

	// Generation mechanism of a configuration code
	function automatic ccm_mode_t ccm_mode_of(input logic [2:0] code);
		ccm_mode_t m;
		m = CCM_MODE_PLL;
		case (code)
			CCM_CODE_PRESC: begin
				m = CCM_MODE_PRESC;
			end
			CCM_CODE_DIRECT: begin
				m = CCM_MODE_DIRECT;
			end
			default: begin
				m = CCM_MODE_PLL;
			end
		endcase
		return m;
	endfunction

	// R3: field extraction
	// Registered copy so every consumer sees one settled value
	always_ff @(posedge core_clk) begin
		if (rst) begin
			clock_config_field <= CCM_CODE_X4;
		end else begin
			clock_config_field <= latch_field;
		end
	end

	// R5: factor decode
	always_ff @(posedge core_clk) begin
		if (rst) begin
			factor_half <= ccm_factor_half(CCM_CODE_X4);
		end else begin
			factor_half <= ccm_factor_half(latch_field);
		end
	end

	// R5: mode decode
	// Mode and flags share the field timing, one cycle behind the latch
	always_ff @(posedge core_clk) begin
		if (rst) begin
			mode <= CCM_MODE_PLL;
		end else begin
			mode <= ccm_mode_of(latch_field);
		end
	end

	// R6: multiplier bypass flags
	always_ff @(posedge core_clk) begin
		if (rst) begin
			prescaler_active <= 1'b0;
			pll_enable       <= 1'b1;
		end else begin
			prescaler_active <= (latch_field == CCM_CODE_PRESC);
			pll_enable       <= (latch_field != CCM_CODE_PRESC)
				&& (latch_field != CCM_CODE_DIRECT);
		end
	end

	// R6: prescaler bypasses the multiplier
	// R7: half rate, R8: each phase one oscillator period
	// Toggling on every oscillator rise gives exactly 50% duty
	always_ff @(posedge core_clk) begin
		if (rst || rst_pin_s) begin
			cpu_clk_presc <= 1'b0;
		end else if (mode == CCM_MODE_PRESC && osc_rise) begin
			cpu_clk_presc <= ~cpu_clk_presc;
		end
	end

	// R1: both edges produce activity strobes
	// The multiplied PLL clock is analog and lives outside; strobes cover 1:1 and 2:1
	always_ff @(posedge core_clk) begin
		if (rst) begin
			cpu_edge_pulse <= 1'b0;
			cpu_rise_pulse <= 1'b0;
			cpu_fall_pulse <= 1'b0;
		end else if (mode == CCM_MODE_PRESC) begin
			cpu_edge_pulse <= osc_rise && !rst_pin_s;
			cpu_rise_pulse <= osc_rise && !rst_pin_s && !cpu_clk_presc;
			cpu_fall_pulse <= osc_rise && !rst_pin_s && cpu_clk_presc;
		end else if (mode == CCM_MODE_DIRECT) begin
			cpu_edge_pulse <= osc_edge;
			cpu_rise_pulse <= osc_rise;
			cpu_fall_pulse <= osc_edge && !osc_s;
		end else begin
			cpu_edge_pulse <= 1'b0;
			cpu_rise_pulse <= 1'b0;
			cpu_fall_pulse <= 1'b0;
		end
	end

	// R2: measure clock phase time in core cycles between edges
	// Saturates so a stalled oscillator does not wrap
	always_ff @(posedge core_clk) begin
		if (rst) begin
			phase_cnt        <= 8'h00;
			clock_phase_time <= 8'h00;
		end else if (cpu_edge_pulse) begin
			clock_phase_time <= phase_cnt;
			phase_cnt        <= 8'h01;
		end else if (phase_cnt != 8'hff) begin
			phase_cnt <= phase_cnt + 8'h01;
		end
	end

	// Register reads; all registers are read-only, writes are ignored
	always_ff @(posedge core_clk) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			if (reg_addr == CCM_ADDR_LATCH) begin
				reg_rdata <= reset_config_latch_high;
			end else if (reg_addr == CCM_ADDR_MODE) begin
				reg_rdata <= {pll_enable, prescaler_active, 2'h0, factor_half};
			end else if (reg_addr == CCM_ADDR_PHASE) begin
				reg_rdata <= clock_phase_time;
			end else begin
				reg_rdata <= 8'h00;
			end
		end else begin
			reg_rdata <= 8'h00;
		end
	end

	// R9: latch stable outside pin reset
	a_latch_hold: assert property (@(posedge core_clk) disable iff (rst) // R9
		!rst_pin_s && !$past(rst_pin_s) |=> $stable(reset_config_latch_high))
		else $error("config latch changed outside reset");
	// R4: capture of strap levels
	a_strap_capture: assert property (@(posedge core_clk) disable iff (rst) // R4
		rst_pin_s |=> reset_config_latch_high == $past(port_s))
		else $error("strap level not captured");
	// R3: field follows latch bits
	a_field_bits: assert property (@(posedge core_clk) disable iff (rst) // R3
		##1 clock_config_field == $past(reset_config_latch_high[7:5]))
		else $error("config field mismatch");
	// R5: direct code sets unity factor
	a_direct_unity: assert property (@(posedge core_clk) disable iff (rst) // R5
		clock_config_field == 3'h3 |-> factor_half == 4'h2)
		else $error("direct code factor wrong");
	// R5: default code sets factor four
	a_default_x4: assert property (@(posedge core_clk) disable iff (rst) // R5
		clock_config_field == 3'h7 |-> factor_half == 4'h8 && pll_enable)
		else $error("default code factor wrong");
	// R6: prescaler disables pll
	a_presc_bypass: assert property (@(posedge core_clk) disable iff (rst) // R6
		prescaler_active |-> !pll_enable && factor_half == 4'h1)
		else $error("prescaler did not bypass multiplier");
	// R7: prescaler clock toggles on oscillator rise
	a_presc_half: assert property (@(posedge core_clk) disable iff (rst) // R7
		mode == CCM_MODE_PRESC && osc_rise && !rst_pin_s |=> cpu_clk_presc != $past(cpu_clk_presc))
		else $error("prescaler missed toggle");
	// R8: no toggle without oscillator rise
	a_presc_phase: assert property (@(posedge core_clk) disable iff (rst) // R8
		!osc_rise && !rst_pin_s |=> $stable(cpu_clk_presc))
		else $error("prescaler phase shorter than period");
	// R1: each edge strobe is a rise or fall
	a_edge_split: assert property (@(posedge core_clk) disable iff (rst) // R1
		cpu_edge_pulse |-> cpu_rise_pulse ^ cpu_fall_pulse)
		else $error("edge strobe not split");
	// R2: phase time latched at edge
	a_phase_meas: assert property (@(posedge core_clk) disable iff (rst) // R2
		cpu_edge_pulse |=> clock_phase_time == $past(phase_cnt))
		else $error("phase time not captured");
	// R5: pll enable per code
	a_pll_codes: assert property (@(posedge core_clk) disable iff (rst) // R5
		pll_enable == (clock_config_field != 3'h1 && clock_config_field != 3'h3))
		else $error("pll enable does not match code");
	// R6: prescaler flag per code
	a_presc_flag: assert property (@(posedge core_clk) disable iff (rst) // R6
		prescaler_active == (clock_config_field == 3'h1))
		else $error("prescaler flag does not match code");
	// R5: code 000 factor
	a_code_x2p5: assert property (@(posedge core_clk) disable iff (rst) // R5
		clock_config_field == 3'h0 |-> factor_half == 4'h5)
		else $error("code 000 factor wrong");
	// R5: code 010 factor
	a_code_x1p5: assert property (@(posedge core_clk) disable iff (rst) // R5
		clock_config_field == 3'h2 |-> factor_half == 4'h3)
		else $error("code 010 factor wrong");
	// R5: code 100 factor
	a_code_x5: assert property (@(posedge core_clk) disable iff (rst) // R5
		clock_config_field == 3'h4 |-> factor_half == 4'ha)
		else $error("code 100 factor wrong");
	// R5: code 101 factor
	a_code_x2: assert property (@(posedge core_clk) disable iff (rst) // R5
		clock_config_field == 3'h5 |-> factor_half == 4'h4)
		else $error("code 101 factor wrong");
	// R5: code 110 factor
	a_code_x3: assert property (@(posedge core_clk) disable iff (rst) // R5
		clock_config_field == 3'h6 |-> factor_half == 4'h6)
		else $error("code 110 factor wrong");
	// R1: rise strobe level
	a_rise_level: assert property (@(posedge core_clk) disable iff (rst) // R1
		$past(mode == CCM_MODE_PRESC) && cpu_rise_pulse |-> cpu_clk_presc)
		else $error("rise strobe with clock low");
	// R1: fall strobe level
	a_fall_level: assert property (@(posedge core_clk) disable iff (rst) // R1
		$past(mode == CCM_MODE_PRESC) && cpu_fall_pulse |-> !cpu_clk_presc)
		else $error("fall strobe with clock high");
	// R1: direct drive edges
	a_direct_edges: assert property (@(posedge core_clk) disable iff (rst) // R1
		!$past(rst) && $past(mode == CCM_MODE_DIRECT) |-> cpu_edge_pulse == $past(osc_edge))
		else $error("direct drive edge strobe wrong");
	// R1: no strobes in pll
	a_pll_quiet: assert property (@(posedge core_clk) disable iff (rst) // R1
		$past(mode == CCM_MODE_PLL) |-> !cpu_edge_pulse)
		else $error("edge strobe in pll mode");
	// R7: prescaler held in reset
	a_presc_gate: assert property (@(posedge core_clk) disable iff (rst) // R7
		rst_pin_s |=> !cpu_clk_presc)
		else $error("prescaler clock ran under pin reset");
	// R3: read data idle
	a_rdata_idle: assert property (@(posedge core_clk) disable iff (rst) // R3
		!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data not idle");
	// R3: latch read back
	a_rdata_latch: assert property (@(posedge core_clk) disable iff (rst) // R3
		reg_rd && reg_addr == CCM_ADDR_LATCH |=> reg_rdata == $past(reset_config_latch_high))
		else $error("latch read wrong");
	// R5: mode read back
	a_rdata_mode: assert property (@(posedge core_clk) disable iff (rst) // R5
		reg_rd && reg_addr == CCM_ADDR_MODE |=> reg_rdata == {$past(pll_enable),
			$past(prescaler_active), 2'h0, $past(factor_half)})
		else $error("mode read wrong");
	// R2: phase read back
	a_rdata_phase: assert property (@(posedge core_clk) disable iff (rst) // R2
		reg_rd && reg_addr == CCM_ADDR_PHASE |=> reg_rdata == $past(clock_phase_time))
		else $error("phase read wrong");
	// R3: unmapped reads zero
	a_rdata_unmapped: assert property (@(posedge core_clk) disable iff (rst) // R3
		reg_rd && reg_addr > CCM_ADDR_PHASE |=> reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	// R9: field held after capture
	a_field_hold: assert property (@(posedge core_clk) disable iff (rst) // R9
		!$past(rst) && !$past(rst_pin_s, 2) |-> $stable(clock_config_field))
		else $error("config field changed outside reset");
endmodule
`default_nettype wire

//--- dv/ccm_strap_model.sv
// Far-side model: strap levels on the upper port byte and a free-running oscillator.
// Assumes core_clk is the bench clock; the oscillator toggles on its rising edges.
`timescale 1ns/10ps
`default_nettype none
module ccm_strap_model (
	input  wire logic       core_clk,
	input  wire logic       strap_drive,
	input  wire logic [2:0] strap_code,
	input  wire logic [7:0] osc_half,
	output var  logic [7:0] port0_upper_byte,
	output var  logic       osc_in
);
	logic [7:0] osc_cnt = 8'h00;

	// straps on top pins
	// Released pins float to the pull-up level, which is the default code
	always_comb port0_upper_byte = strap_drive ? {strap_code, 5'h0a} : 8'hff;

	// Oscillator runs free; half period counted in core cycles
	initial osc_in = 1'b0;
	always @(posedge core_clk) begin
		if (osc_cnt + 8'h01 >= osc_half) begin
			osc_cnt <= 8'h00;
			osc_in  <= ~osc_in;
		end else begin
			osc_cnt <= osc_cnt + 8'h01;
		end
	end
endmodule
`default_nettype wire

//--- dv/tb_cpu_clock_mode_select.sv
// Self-checking bench for the CPU clock mode selector.
// Assumes the strap model on the far side; registers read over the plain port.
`timescale 1ns/10ps
`default_nettype none
module tb_cpu_clock_mode_select;
	import ccm_pkg::*;
	logic       core_clk = 1'b0, rst = 1'b1, hw_reset_long = 1'b0;
	logic       strap_drive = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [2:0] strap_code = 3'h0;
	logic [7:0] osc_half = 8'h05, reg_wdata = 8'h00, reg_rdata, port0_upper_byte;
	logic [3:0] reg_addr = 4'h0, factor_half;
	logic [2:0] clock_config_field;
	logic       osc_in, prescaler_active, pll_enable, cpu_clk_presc;
	logic       cpu_edge_pulse, cpu_rise_pulse, cpu_fall_pulse;
	int         fails = 0, check_count = 0;
	// Expected factor in halves, indexed by code
	localparam logic [3:0] EXP_FAC [8] = '{4'h5, 4'h1, 4'h3, 4'h2, 4'ha, 4'h4, 4'h6, 4'h8};

	always #2 core_clk = ~core_clk;

	ccm_strap_model i_ccm_strap_model (.core_clk(core_clk), .strap_drive(strap_drive),
		.strap_code(strap_code), .osc_half(osc_half),
		.port0_upper_byte(port0_upper_byte), .osc_in(osc_in));
	ccm_top i_ccm_top (.core_clk(core_clk), .rst(rst), .hw_reset_long(hw_reset_long),
		.port0_upper_byte(port0_upper_byte), .osc_in(osc_in), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.clock_config_field(clock_config_field), .factor_half(factor_half),
		.prescaler_active(prescaler_active), .pll_enable(pll_enable),
		.cpu_clk_presc(cpu_clk_presc), .cpu_edge_pulse(cpu_edge_pulse),
		.cpu_rise_pulse(cpu_rise_pulse), .cpu_fall_pulse(cpu_fall_pulse));

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			fails++;
			$display("mismatch t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge core_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask

	// Long pin reset with straps held, then straps released to pull-ups
	task automatic capture(input logic [2:0] code);
		@(posedge core_clk);
		strap_code    <= code;
		strap_drive   <= 1'b1;
		hw_reset_long <= 1'b1;
		repeat (10) @(posedge core_clk);
		hw_reset_long <= 1'b0;
		repeat (8) @(posedge core_clk);
		strap_drive <= 1'b0;
		repeat (8) @(posedge core_clk);
	endtask

	task automatic t_reset_values();
		rd(CCM_ADDR_LATCH, 8'hff);
		rd(CCM_ADDR_MODE, 8'h88);
		rd(4'h3, 8'h00);
		@(posedge core_clk);
		reg_wr    <= 1'b1;
		reg_wdata <= 8'h00;
		reg_addr  <= CCM_ADDR_LATCH;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		rd(CCM_ADDR_LATCH, 8'hff);
	endtask

	// Every code captured, decoded, and kept after the straps let go
	task automatic t_all_codes();
		logic presc, pll;
		for (int c = 0; c < 8; c++) begin
			capture(3'(c));
			presc = (c == 1);
			pll   = (c != 1) && (c != 3);
			#1 chk({5'h0, clock_config_field}, 8'(c));
			chk({4'h0, factor_half}, {4'h0, EXP_FAC[c]});
			chk({6'h0, pll_enable, prescaler_active}, {6'h0, pll, presc});
			rd(CCM_ADDR_LATCH, {3'(c), 5'h0a});
			rd(CCM_ADDR_MODE, {pll, presc, 2'b00, EXP_FAC[c]});
		end
	endtask

	// Interval between CPU clock edges, edge kinds alternate
	task automatic t_phase(input logic [2:0] code, input logic [7:0] h, input logic [7:0] per);
		int   n;
		logic r;
		osc_half <= h;
		capture(code);
		// Look after the edge so the strobes are settled
		#1;
		n = 0;
		while (cpu_edge_pulse !== 1'b1 && n < 1000) begin
			@(posedge core_clk);
			#1 n++;
		end
		r = cpu_rise_pulse;
		n = 0;
		do begin
			@(posedge core_clk);
			#1 n++;
		end while (cpu_edge_pulse !== 1'b1 && n < 1000);
		chk(8'(n), per);
		chk({7'h0, cpu_fall_pulse}, {7'h0, r});
		chk({7'h0, cpu_clk_presc}, {7'h0, (code == CCM_CODE_PRESC) && !r});
		rd(CCM_ADDR_PHASE, per);
	endtask

	task automatic final_report();
		$display("checks %0d fails %0d", check_count, fails);
		if (fails == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	initial begin
		repeat (12) @(posedge core_clk);
		rst <= 1'b0;
		t_reset_values();
		t_all_codes();
		t_phase(CCM_CODE_PRESC, 8'h06, 8'd12);
		t_phase(CCM_CODE_PRESC, 8'h09, 8'd18);
		t_phase(CCM_CODE_DIRECT, 8'h05, 8'd5);
		final_report();
	end

	// Watchdog: the run needs a few thousand cycles at most
	initial begin
		#40000;
		fails++;
		final_report();
	end
endmodule
`default_nettype wire
